// ---- include/isc_pkg.sv ----
// constants, types and register map of the i2c slave configuration slice
// assumes one system clock and an AXI4-Lite master with 32-bit data
// Summary of operation
// R1: each channel has a read/write general call id register used only in slave mode.
// R2: software writes zero to every reserved bit of the configuration register.
// R3: with config bit 14 set a stop after a valid start and address match raises an interrupt.
// R4: with config bit 11 set the device holds SCL low; clearing it releases SCL.
// R5: with config bit 9 clear a tx fifo request fires right after the r/w bit falling clock edge.
// R6: setting config bit 9 disables the tx fifo request interrupt.
// R7: software answers the tx fifo request within 45 core cycles at 400 ksps and 41.78 MHz.
// R8: with both general call enables set, the byte after a general call is compared with the id.
// R9: writing one to config bit 8 clears the general call status; hardware then clears bit 8.
// R10: both registers of both channels reset to zero.
package isc_pkg;
    localparam int NCH = 2;
    // =====================================================
    // register map (byte addresses)
    localparam logic [31:0] CH0_GCID_OFS = 32'hFFFF0828;
    localparam logic [31:0] CH0_CFG_OFS = 32'hFFFF082C;
    localparam logic [31:0] CH1_GCID_OFS = 32'hFFFF0928;
    localparam logic [31:0] CH1_CFG_OFS = 32'hFFFF092C;
    localparam logic [31:0] IRQ_STAT_OFS = 32'hFFFF0A00;
    localparam logic [31:0] IRQ_MASK_OFS = 32'hFFFF0A04;
    // =====================================================
    // configuration fields
    localparam int CFG_STOP_IE = 14;
    localparam int CFG_STRETCH = 11;
    localparam int CFG_TXREQ_DIS = 9;
    localparam int CFG_GC_CLR = 8;
    localparam int CFG_HWGC_EN = 4;
    localparam int CFG_GC_EN = 3;
    localparam int CFG_LOW_W = 8;
    localparam logic [31:0] CFG_WMASK = 32'h00004BFB;
    localparam logic [31:0] CFG_RST = 32'h00000000;
    localparam logic [7:0] GCID_RST = 8'h00;
    // =====================================================
    // interrupt status layout: channel n uses bits 4n..4n+2
    localparam int IRQ_STOP = 0;
    localparam int IRQ_TXREQ = 1;
    localparam int IRQ_HWGC = 2;
    localparam int IRQ_STRIDE = 4;
    localparam logic [7:0] IRQ_WMASK = 8'h77;
    localparam logic [7:0] IRQ_RST = 8'h00;
    // =====================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_GCID0 = 3'h1,
        SEL_CFG0 = 3'h3,
        SEL_GCID1 = 3'h2,
        SEL_CFG1 = 3'h6,
        SEL_ISTAT = 3'h7,
        SEL_IMASK = 3'h5
    } isc_sel_t;
    typedef struct packed {
        logic st_seen;
        logic in_sess;
        logic gc_wait;
        logic gc_any;
        logic gc_hw;
        logic ev_stop;
        logic ev_txreq;
        logic ev_hwgc;
    } isc_chan_st_t;
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [31:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NCH-1:0][31:0] cfg;
        logic [NCH-1:0][7:0] gcid;
        logic [7:0] ists;
        logic [7:0] imask;
    } isc_top_st_t;
endpackage : isc_pkg

// ---- include/isc_chan_if.sv ----
// per-channel link between the register file and the channel event logic
// assumes both ends run on the same system clock
`timescale 1ns/100ps
interface isc_chan_if;
    logic [31:0] cfg;
    logic [7:0] gcid;
    logic ev_stop;
    logic ev_txreq;
    logic ev_hwgc;
    logic gc_any;
    logic gc_hw;
    logic clr_done;
    modport regs (output cfg, gcid, input ev_stop, ev_txreq, ev_hwgc, gc_any, gc_hw, clr_done);
    modport chan (input cfg, gcid, output ev_stop, ev_txreq, ev_hwgc, gc_any, gc_hw, clr_done);
endinterface : isc_chan_if

// ---- verilog/isc_chan_evt.sv ----
// event and general call logic of one i2c slave channel
// assumes the slave engine gives one-cycle pulses synchronous to clk
`timescale 1ns/100ps
module isc_chan_evt
    import isc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start_det,
    input wire logic stop_det,
    input wire logic addr_match,
    input wire logic rw_fall,
    input wire logic gc_addr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    output logic scl_o,
    output logic scl_oe_n,
    isc_chan_if.chan bus
);
    isc_chan_st_t s_ff;
    isc_chan_st_t nxt_s;

    // =====================================================
    // next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.ev_stop = 1'b0;
        nxt_s.ev_txreq = 1'b0;
        nxt_s.ev_hwgc = 1'b0;
        if (bus.cfg[CFG_GC_CLR]) begin // R9
            nxt_s.gc_any = 1'b0;
            nxt_s.gc_hw = 1'b0;
        end
        if (start_det) begin
            nxt_s.st_seen = 1'b1;
        end
        if (addr_match && (s_ff.st_seen || start_det)) begin
            nxt_s.in_sess = 1'b1;
        end
        if (stop_det) begin
            nxt_s.ev_stop = s_ff.in_sess && bus.cfg[CFG_STOP_IE]; // R3
            nxt_s.in_sess = 1'b0;
            nxt_s.st_seen = 1'b0;
            nxt_s.gc_wait = 1'b0;
        end
        nxt_s.ev_txreq = rw_fall && !bus.cfg[CFG_TXREQ_DIS]; // R5 R6
        if (gc_addr && bus.cfg[CFG_GC_EN]) begin
            nxt_s.gc_any = 1'b1;
            nxt_s.gc_wait = bus.cfg[CFG_HWGC_EN];
        end
        if (rx_valid && s_ff.gc_wait) begin // R8
            nxt_s.gc_wait = 1'b0;
            if (rx_byte == bus.gcid) begin
                nxt_s.gc_hw = 1'b1;
                nxt_s.ev_hwgc = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // =====================================================
    // outputs
    assign scl_o = 1'b0;
    assign scl_oe_n = !bus.cfg[CFG_STRETCH]; // R4
    assign bus.ev_stop = s_ff.ev_stop;
    assign bus.ev_txreq = s_ff.ev_txreq;
    assign bus.ev_hwgc = s_ff.ev_hwgc;
    assign bus.gc_any = s_ff.gc_any;
    assign bus.gc_hw = s_ff.gc_hw;
    assign bus.clr_done = bus.cfg[CFG_GC_CLR]; // R9

    // =====================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    stop_irq_on_a: assert property (stop_det && s_ff.in_sess && bus.cfg[CFG_STOP_IE] // R3
        |=> bus.ev_stop) else $error("stop interrupt missing");
    stop_irq_off_a: assert property (bus.ev_stop // R3
        |-> $past(bus.cfg[CFG_STOP_IE]) && $past(stop_det) && $past(s_ff.in_sess))
        else $error("stop interrupt without cause");
    txreq_fire_a: assert property (rw_fall && !bus.cfg[CFG_TXREQ_DIS] // R5
        |=> bus.ev_txreq) else $error("tx request missing");
    txreq_mask_a: assert property (bus.ev_txreq // R6
        |-> $past(!bus.cfg[CFG_TXREQ_DIS]) && $past(rw_fall))
        else $error("tx request while disabled");
    scl_hold_a: assert property (bus.cfg[CFG_STRETCH] |-> !scl_oe_n && !scl_o // R4
        ##1 (bus.cfg[CFG_STRETCH] || scl_oe_n)) else $error("scl stretch wrong");
    hwgc_match_a: assert property (rx_valid && s_ff.gc_wait && rx_byte == bus.gcid // R8
        |=> bus.gc_hw && bus.ev_hwgc) else $error("hardware general call missed");
    gc_clear_a: assert property (bus.cfg[CFG_GC_CLR] && !gc_addr // R9
        && !(rx_valid && s_ff.gc_wait) |=> !bus.gc_any && !bus.gc_hw)
        else $error("general call status not cleared");
    stop_seen_c: cover property (bus.ev_stop);
    hwgc_seen_c: cover property (bus.ev_hwgc);
endmodule : isc_chan_evt

// ---- verilog/isc_cfg_top.sv ----
// AXI4-Lite register file of both i2c channels with interrupt status and mask
// assumes slave engine pulses are synchronous to SYS_CLK
`timescale 1ns/100ps
module isc_cfg_top
    import isc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [NCH-1:0] START_DET,
    input wire logic [NCH-1:0] STOP_DET,
    input wire logic [NCH-1:0] ADDR_MATCH,
    input wire logic [NCH-1:0] RW_FALL,
    input wire logic [NCH-1:0] GC_ADDR,
    input wire logic [NCH-1:0] RX_VALID,
    input wire logic [NCH*8-1:0] RX_BYTE,
    output logic [NCH-1:0] SCL_O,
    output logic [NCH-1:0] SCL_OE_N,
    output logic [NCH-1:0] GC_ANY,
    output logic [NCH-1:0] GC_HW,
    output logic [NCH*CFG_LOW_W-1:0] CFG_LOW,
    output logic IRQ
);
    isc_top_st_t s_ff;
    isc_top_st_t nxt_s;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_commit;
    isc_sel_t wr_sel;
    logic [7:0] ev_vec;
    logic [NCH-1:0] clr_done;

    // =====================================================
    // helpers
    function automatic isc_sel_t reg_sel(input logic [31:0] addr);
        unique case (addr)
            CH0_GCID_OFS: reg_sel = SEL_GCID0;
            CH0_CFG_OFS: reg_sel = SEL_CFG0;
            CH1_GCID_OFS: reg_sel = SEL_GCID1;
            CH1_CFG_OFS: reg_sel = SEL_CFG1;
            IRQ_STAT_OFS: reg_sel = SEL_ISTAT;
            IRQ_MASK_OFS: reg_sel = SEL_IMASK;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction : reg_sel

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        strb_merge = r;
    endfunction : strb_merge

    // =====================================================
    // channels
    isc_chan_if chif [NCH] ();

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        assign chif[c].cfg = s_ff.cfg[c];
        assign chif[c].gcid = s_ff.gcid[c]; // R1
        assign ev_vec[c*IRQ_STRIDE + IRQ_STOP] = chif[c].ev_stop;
        assign ev_vec[c*IRQ_STRIDE + IRQ_TXREQ] = chif[c].ev_txreq;
        assign ev_vec[c*IRQ_STRIDE + IRQ_HWGC] = chif[c].ev_hwgc;
        assign ev_vec[c*IRQ_STRIDE + 3] = 1'b0;
        assign clr_done[c] = chif[c].clr_done;
        assign GC_ANY[c] = chif[c].gc_any;
        assign GC_HW[c] = chif[c].gc_hw;
        assign CFG_LOW[c*CFG_LOW_W +: CFG_LOW_W] = s_ff.cfg[c][CFG_LOW_W-1:0];
        isc_chan_evt u_chan (
            .clk(SYS_CLK),
            .rst(SYS_RST),
            .start_det(START_DET[c]),
            .stop_det(STOP_DET[c]),
            .addr_match(ADDR_MATCH[c]),
            .rw_fall(RW_FALL[c]),
            .gc_addr(GC_ADDR[c]),
            .rx_valid(RX_VALID[c]),
            .rx_byte(RX_BYTE[c*8 +: 8]),
            .scl_o(SCL_O[c]),
            .scl_oe_n(SCL_OE_N[c]),
            .bus(chif[c])
        );
    end

    // =====================================================
    // bus handshakes
    assign S_AXI_AWREADY = !s_ff.aw_got && !s_ff.bvalid;
    assign S_AXI_WREADY = !s_ff.w_got && !s_ff.bvalid;
    assign S_AXI_ARREADY = !s_ff.rvalid;
    assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_hs = S_AXI_WVALID && S_AXI_WREADY;
    assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
    assign wr_commit = (s_ff.aw_got || aw_hs) && (s_ff.w_got || w_hs) && !s_ff.bvalid;
    assign wr_sel = reg_sel(aw_hs ? S_AXI_AWADDR : s_ff.awaddr);

    // =====================================================
    // next state
    always_comb begin
        logic [31:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic [31:0] old;
        logic [31:0] wr;
        wa = aw_hs ? S_AXI_AWADDR : s_ff.awaddr;
        wd = w_hs ? S_AXI_WDATA : s_ff.wdata;
        ws = w_hs ? S_AXI_WSTRB : s_ff.wstrb;
        old = '0;
        nxt_s = s_ff;
        if (aw_hs) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.awaddr = S_AXI_AWADDR;
        end
        if (w_hs) begin
            nxt_s.w_got = 1'b1;
            nxt_s.wdata = S_AXI_WDATA;
            nxt_s.wstrb = S_AXI_WSTRB;
        end
        if (s_ff.bvalid && S_AXI_BREADY) begin
            nxt_s.bvalid = 1'b0;
        end
        for (int c = 0; c < NCH; c++) begin
            if (clr_done[c]) begin
                nxt_s.cfg[c][CFG_GC_CLR] = 1'b0; // R9
            end
        end
        unique case (wr_sel)
            SEL_GCID0: old = {24'h000000, s_ff.gcid[0]};
            SEL_CFG0: old = s_ff.cfg[0];
            SEL_GCID1: old = {24'h000000, s_ff.gcid[1]};
            SEL_CFG1: old = s_ff.cfg[1];
            SEL_ISTAT: old = 32'h00000000;
            SEL_IMASK: old = {24'h000000, s_ff.imask};
            SEL_NONE: old = 32'h00000000;
        endcase
        wr = strb_merge(old, wd, ws);
        if (wr_commit) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = (reg_sel(wa) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            unique case (wr_sel)
                SEL_GCID0: nxt_s.gcid[0] = wr[7:0]; // R1
                SEL_CFG0: nxt_s.cfg[0] = wr & CFG_WMASK; // R2
                SEL_GCID1: nxt_s.gcid[1] = wr[7:0]; // R1
                SEL_CFG1: nxt_s.cfg[1] = wr & CFG_WMASK; // R2
                SEL_ISTAT: nxt_s.ists = s_ff.ists & ~(wd[7:0] & {8{ws[0]}});
                SEL_IMASK: nxt_s.imask = wr[7:0] & IRQ_WMASK;
                SEL_NONE: nxt_s.bresp = RESP_SLVERR;
            endcase
        end
        // events win over a clear in the same cycle
        nxt_s.ists = nxt_s.ists | ev_vec;
        if (s_ff.rvalid && S_AXI_RREADY) begin
            nxt_s.rvalid = 1'b0;
        end
        if (ar_hs) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = RESP_OKAY;
            unique case (reg_sel(S_AXI_ARADDR))
                SEL_GCID0: nxt_s.rdata = {24'h000000, s_ff.gcid[0]}; // R1
                SEL_CFG0: nxt_s.rdata = s_ff.cfg[0];
                SEL_GCID1: nxt_s.rdata = {24'h000000, s_ff.gcid[1]}; // R1
                SEL_CFG1: nxt_s.rdata = s_ff.cfg[1];
                SEL_ISTAT: nxt_s.rdata = {24'h000000, s_ff.ists};
                SEL_IMASK: nxt_s.rdata = {24'h000000, s_ff.imask};
                SEL_NONE: begin
                    nxt_s.rdata = 32'h00000000;
                    nxt_s.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            s_ff <= '0; // R10
            s_ff.cfg <= {NCH{CFG_RST}};
            s_ff.gcid <= {NCH{GCID_RST}};
            s_ff.ists <= IRQ_RST;
            s_ff.imask <= IRQ_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // =====================================================
    // outputs
    assign S_AXI_BVALID = s_ff.bvalid;
    assign S_AXI_BRESP = s_ff.bresp;
    assign S_AXI_RVALID = s_ff.rvalid;
    assign S_AXI_RDATA = s_ff.rdata;
    assign S_AXI_RRESP = s_ff.rresp;
    assign IRQ = |(s_ff.ists & s_ff.imask);

    // =====================================================
    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    reset_zero_a: assert property ($fell(SYS_RST) |-> s_ff.cfg == '0 && s_ff.gcid == '0) // R10
        else $error("registers not zero after reset");
    gcid_stable_a: assert property (!wr_commit |=> $stable(s_ff.gcid)) // R1
        else $error("general call id changed without a write");
    gc_selfclr_a: assert property (s_ff.cfg[0][CFG_GC_CLR] // R9
        && !(wr_commit && wr_sel == SEL_CFG0) |=> !s_ff.cfg[0][CFG_GC_CLR])
        else $error("clear bit not self cleared");
    cfg_resv_a: assert property (s_ff.cfg[1] == (s_ff.cfg[1] & CFG_WMASK)) // R2
        else $error("reserved config bits set");
    wr_resp_a: assert property (wr_commit |=> S_AXI_BVALID)
        else $error("write response missing");
    irq_c: cover property (IRQ);
    txreq_c: cover property (s_ff.ists[IRQ_TXREQ]);
    rd_c: cover property (S_AXI_RVALID && S_AXI_RREADY && S_AXI_RRESP == RESP_OKAY);
endmodule : isc_cfg_top

// ---- verification/isc_remote_master.sv ----
// remote i2c master model driving the per-channel event pulses of the slave engine
// assumes the bench calls its tasks; every pulse lasts one system clock
`timescale 1ns/100ps
module isc_remote_master
    import isc_pkg::*;
(
    input wire logic clk,
    output logic [NCH-1:0] start_det,
    output logic [NCH-1:0] stop_det,
    output logic [NCH-1:0] addr_match,
    output logic [NCH-1:0] rw_fall,
    output logic [NCH-1:0] gc_addr,
    output logic [NCH-1:0] rx_valid,
    output logic [NCH*8-1:0] rx_byte
);
    // =====================================================
    // idle bus
    initial begin
        start_det = '0;
        stop_det = '0;
        addr_match = '0;
        rw_fall = '0;
        gc_addr = '0;
        rx_valid = '0;
        rx_byte = {NCH{8'hC3}};
    end
    // =====================================================
    // one bus event per call; k is {rx, gc, rw, match, stop, start}
    task automatic pulse(input int c, input logic [5:0] k, input logic [7:0] b);
        @(posedge clk);
        start_det[c] <= k[0];
        stop_det[c] <= k[1];
        addr_match[c] <= k[2];
        rw_fall[c] <= k[3];
        gc_addr[c] <= k[4];
        rx_valid[c] <= k[5];
        rx_byte[c*8+:8] <= b;
        @(posedge clk);
        start_det[c] <= 1'b0;
        stop_det[c] <= 1'b0;
        addr_match[c] <= 1'b0;
        rw_fall[c] <= 1'b0;
        gc_addr[c] <= 1'b0;
        rx_valid[c] <= 1'b0;
        // a released data line must not keep showing the last byte
        rx_byte[c*8+:8] <= ~b;
    endtask : pulse
    // =====================================================
    // transfer: start, optional match, optional r/w bit, optional stop
    task automatic session(input int c, input logic m, input logic rw, input logic st);
        pulse(c, 6'h01, 8'h3C);
        if (m) pulse(c, 6'h04, 8'h3C);
        if (rw) pulse(c, 6'h08, 8'h3C);
        if (st) pulse(c, 6'h02, 8'h3C);
    endtask : session
    task automatic gen_call(input int c, input logic [7:0] b);
        pulse(c, 6'h01, 8'h3C);
        pulse(c, 6'h10, 8'h3C);
        pulse(c, 6'h20, b);
    endtask : gen_call
endmodule : isc_remote_master

// ---- verification/testbench.sv ----
// self-checking bench of the i2c slave configuration slice over AXI4-Lite
// assumes isc_remote_master stands in for the far side of both channels
`timescale 1ns/100ps
module testbench;
    import isc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [NCH-1:0] start_det, stop_det, addr_match, rw_fall, gc_addr, rx_valid;
    logic [NCH-1:0] scl_o, scl_oe_n, gc_any, gc_hw;
    logic [NCH*8-1:0] rx_byte;
    logic [NCH*CFG_LOW_W-1:0] cfg_low;
    logic [31:0] gcid_ofs [NCH] = '{CH0_GCID_OFS, CH1_GCID_OFS};
    logic [31:0] cfg_ofs [NCH] = '{CH0_CFG_OFS, CH1_CFG_OFS};
    int mismatches = 0;
    int check_count = 0;
    initial begin
        forever #2 clk = ~clk;
    end
    isc_cfg_top u_isc_cfg_top (.SYS_CLK(clk), .SYS_RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .START_DET(start_det), .STOP_DET(stop_det), .ADDR_MATCH(addr_match),
        .RW_FALL(rw_fall), .GC_ADDR(gc_addr), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
        .SCL_O(scl_o), .SCL_OE_N(scl_oe_n), .GC_ANY(gc_any), .GC_HW(gc_hw),
        .CFG_LOW(cfg_low), .IRQ(irq));
    isc_remote_master u_isc_remote_master (.clk(clk), .start_det(start_det),
        .stop_det(stop_det), .addr_match(addr_match), .rw_fall(rw_fall), .gc_addr(gc_addr),
        .rx_valid(rx_valid), .rx_byte(rx_byte));
    // =====================================================
    // report and compare
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word
    task automatic chk_flag(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask : chk_flag
    task automatic hang(input string n);
        mismatches++;
        $display("CHECK FAILED %s expected answer seen timeout", n);
        test_done();
    endtask : hang
    // =====================================================
    // AXI4-Lite master
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hit, w_hit, b_hit;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_hit = 1'b0;
        for (int n = 0; n < 50 && !b_hit; n++) begin
            #1;
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid && bready;
            r = bresp;
            @(posedge clk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!b_hit) hang("write answer");
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hit, r_hit;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_hit = 1'b0;
        for (int n = 0; n < 50 && !r_hit; n++) begin
            #1;
            ar_hit = arvalid && arready;
            r_hit = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_hit) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!r_hit) hang("read answer");
    endtask : axi_rd
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk_word("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : wr
    task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk_word(n, e, d);
        chk_word("read resp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : rd
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    // =====================================================
    // tests
    initial begin
        logic [31:0] d, bit_s, gc_en;
        logic [1:0] r;
        logic [7:0] s;
        gc_en = (32'h1 << CFG_GC_EN) | (32'h1 << CFG_HWGC_EN);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int c = 0; c < NCH; c++) begin
            rd("id reset", gcid_ofs[c], {24'h0, GCID_RST});
            rd("config reset", cfg_ofs[c], CFG_RST);
            chk_flag("scl reset", 1'b1, scl_oe_n[c]);
        end
        rd("status reset", IRQ_STAT_OFS, 32'h0);
        rd("mask reset", IRQ_MASK_OFS, 32'h0);
        chk_flag("irq reset", 1'b0, irq);
        $display("test reset done");
        for (int c = 0; c < NCH; c++) begin
            s = 8'h5A + 8'(c);
            wr(gcid_ofs[c], {24'hFFFFFF, s});
            rd("id", gcid_ofs[c], {24'h0, s});
            wr(cfg_ofs[c], 32'hFFFFFEFF);
            rd("config", cfg_ofs[c], CFG_WMASK & 32'hFFFFFEFF);
            settle();
            chk_word("low config", 32'hFB, {24'h0, cfg_low[c*8+:8]});
            chk_flag("scl stretch", 1'b0, scl_oe_n[c]);
            chk_flag("scl low", 1'b0, scl_o[c]);
            wr(cfg_ofs[c], 32'h0);
            settle();
            chk_flag("scl release", 1'b1, scl_oe_n[c]);
        end
        axi_rd(32'hFFFF0830, d, r);
        chk_word("unmapped data", 32'h0, d);
        chk_word("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
        axi_wr(32'hFFFF0830, 32'hFFFFFFFF, r);
        chk_word("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
        $display("test registers done");
        wr(IRQ_MASK_OFS, 32'h77);
        for (int c = 0; c < NCH; c++) begin
            bit_s = 32'h1 << (IRQ_STRIDE * c + IRQ_STOP);
            wr(cfg_ofs[c], 32'h1 << CFG_STOP_IE);
            u_isc_remote_master.session(c, 1'b0, 1'b0, 1'b1);
            settle();
            rd("stop no match", IRQ_STAT_OFS, 32'h0);
            u_isc_remote_master.session(c, 1'b1, 1'b0, 1'b1);
            settle();
            rd("stop status", IRQ_STAT_OFS, bit_s);
            chk_flag("stop irq", 1'b1, irq);
            wr(IRQ_STAT_OFS, bit_s);
            settle();
            chk_flag("irq cleared", 1'b0, irq);
            wr(cfg_ofs[c], 32'h0);
            u_isc_remote_master.session(c, 1'b1, 1'b0, 1'b1);
            settle();
            rd("stop disabled", IRQ_STAT_OFS, 32'h0);
        end
        $display("test stop done");
        for (int c = 0; c < NCH; c++) begin
            bit_s = 32'h1 << (IRQ_STRIDE * c + IRQ_TXREQ);
            u_isc_remote_master.session(c, 1'b1, 1'b1, 1'b0);
            settle();
            rd("tx request", IRQ_STAT_OFS, bit_s);
            wr(IRQ_MASK_OFS, 32'h0);
            settle();
            chk_flag("masked irq", 1'b0, irq);
            wr(IRQ_MASK_OFS, 32'h77);
            settle();
            chk_flag("tx irq", 1'b1, irq);
            wr(IRQ_STAT_OFS, bit_s);
            wr(cfg_ofs[c], 32'h1 << CFG_TXREQ_DIS);
            u_isc_remote_master.session(c, 1'b1, 1'b1, 1'b0);
            settle();
            rd("tx disabled", IRQ_STAT_OFS, 32'h0);
            wr(cfg_ofs[c], 32'h0);
        end
        $display("test tx request done");
        for (int c = 0; c < NCH; c++) begin
            s = 8'h5A + 8'(c);
            wr(cfg_ofs[c], gc_en);
            u_isc_remote_master.gen_call(c, ~s);
            settle();
            chk_flag("general call", 1'b1, gc_any[c]);
            chk_flag("id mismatch", 1'b0, gc_hw[c]);
            wr(cfg_ofs[c], gc_en | (32'h1 << CFG_GC_CLR));
            settle();
            chk_flag("gc cleared", 1'b0, gc_any[c]);
            rd("clear bit", cfg_ofs[c], gc_en);
            u_isc_remote_master.gen_call(c, s);
            settle();
            chk_flag("id match", 1'b1, gc_hw[c]);
            rd("hw gc status", IRQ_STAT_OFS, 32'h1 << (IRQ_STRIDE * c + IRQ_HWGC));
            wr(IRQ_STAT_OFS, 32'h77);
            wr(cfg_ofs[c], gc_en | (32'h1 << CFG_GC_CLR));
            settle();
            chk_flag("hw gc cleared", 1'b0, gc_hw[c]);
            wr(cfg_ofs[c], 32'h0);
        end
        $display("test general call done");
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd("id rerun", gcid_ofs[1], {24'h0, GCID_RST});
        $display("test rerun done");
        test_done();
    end
endmodule : testbench
